//--- pic_top.sv
// priority interrupt controller with clock break and power fail sources
`timescale 1ns/1ps
module pic_top #(
  parameter int CLK_LEVEL = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor context
  input wire logic [3:0] hw_req,
  input wire logic indirect_exec,
  input wire logic instr_retire,
  input wire logic monitor_mode,
  input wire logic call_entry,
  input wire logic scale_to_leading_one_instr_entry,
  // clock tick sources and console switch
  input wire logic line_tick,
  input wire logic osc_tick,
  input wire logic ext_tick,
  input wire logic console_clk_allow,
  // memory increment cycle of the i/o processor
  output logic mem_inc_req,
  output logic [17:0] mem_inc_addr,
  input wire logic mem_inc_ack,
  input wire logic mem_inc_ovf,
  // power fail
  input wire logic power_low,
  input wire logic power_clear,
  input wire logic auto_restart,
  // grants and restoration to the processor
  output logic grant,
  output logic [2:0] grant_level,
  output logic [7:0] grant_vector,
  output logic pi_req,
  output logic restore_pulse,
  output logic restore_full,
  output logic restart,
  output logic [17:0] restart_addr
);
  typedef struct packed {
    logic en;
    logic [7:0] req;
    logic [7:0] act;
    logic inhibit;
    logic [1:0] free;
    logic arm;
    logic arm_full;
    logic clk_en;
    logic clk_flag;
    logic [1:0] clk_src;
    logic inc_req;
    logic pwr_flag;
    logic pwr_prev;
    logic tick_prev;
    logic [17:0] result;
    logic skip;
    logic grant;
    logic [2:0] glevel;
    logic [7:0] vector;
    logic pi_req;
    logic rst_pulse;
    logic rst_full;
    logic restart;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } pic_state_s;

  pic_state_s st_q;
  pic_state_s st_d;

  // index of highest priority set bit, level 0 being the highest
  function automatic logic [2:0] top_level(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // true when no active bit at or above the given level
  function automatic logic above_all(input logic [7:0] a,
                                    input logic [2:0] l);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (a[i] && 3'(i) <= l) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  logic access;
  logic wr_fire;
  logic cmd_fire;
  pic_pkg::pic_cmd_e cmd;
  logic [17:0] ac;
  logic tick_sel;
  logic tick_rise;
  logic [7:0] pend;
  logic [2:0] plevel;
  logic may_grant;

  // apb phase decode; pready is registered so access takes two cycles
  assign access = psel && penable;
  assign wr_fire = access && st_q.pready && pwrite;
  assign cmd_fire = wr_fire && paddr == pic_pkg::OFF_CMD;
  assign cmd = pic_pkg::pic_cmd_e'(pwdata[pic_pkg::CMD_LSB +: pic_pkg::CMD_W]);
  assign ac = pwdata[pic_pkg::AC_W-1:0];

  // tick source select; ticks are synchronous levels, counted on rise
  always_comb begin
    tick_sel = line_tick;
    if (st_q.clk_src == pic_pkg::SRC_OSC) begin
      tick_sel = osc_tick;
    end else if (st_q.clk_src == pic_pkg::SRC_EXT) begin
      tick_sel = ext_tick;
    end
  end
  assign tick_rise = tick_sel && !st_q.tick_prev;

  // pending levels: software bits, external lines, power and clock flags
  always_comb begin
    pend = st_q.req;
    pend[3:0] = pend[3:0] | hw_req;
    pend[0] = pend[0] | st_q.pwr_flag;
    pend[CLK_LEVEL] = pend[CLK_LEVEL] | st_q.clk_flag;
  end
  assign plevel = top_level(pend);
  // clock increment holds off every grant, commands too for a clean order
  assign may_grant = st_q.en && !st_q.inhibit && st_q.free == 2'h0 &&
                     !st_q.inc_req && !cmd_fire && !st_q.grant &&
                     |pend && above_all(st_q.act, plevel);

  // next state
  always_comb begin
    st_d = st_q;
    st_d.grant = 1'b0;
    st_d.rst_pulse = 1'b0;
    st_d.restart = 1'b0;
    st_d.pready = access && !st_q.pready;
    st_d.pslverr = 1'b0;
    st_d.tick_prev = tick_sel;
    st_d.pwr_prev = power_low;

    // restoration is applied by the next indirect instruction; placed
    // ahead of the commands so a new arm in the same cycle survives
    if (st_q.arm && indirect_exec) begin
      st_d.arm = 1'b0;
      st_d.rst_pulse = 1'b1;
      st_d.rst_full = st_q.arm_full;
    end

    // register writes and commands
    if (wr_fire && paddr == pic_pkg::OFF_CONFIG) begin
      st_d.clk_src = pwdata[1:0];
    end
    if (cmd_fire) begin
      st_d.skip = 1'b0;
      case (cmd)
        pic_pkg::CMD_SKIP_INACTIVE: begin
          st_d.skip = (ac[17] && st_q.en) ||
                      |(st_q.act & {<<{ac[7:0]}});
        end
        pic_pkg::CMD_RAISE: begin
          st_d.en = ac[17];
          for (int i = 0; i < 4; i++) begin
            st_d.req[4+i] = st_q.req[4+i] | ac[11-i];
          end
          for (int i = 0; i < 8; i++) begin
            st_d.act[i] = st_q.act[i] | ac[7-i];
          end
        end
        pic_pkg::CMD_RELEASE: begin
          if (|st_q.act) begin
            st_d.act[top_level(st_q.act)] = 1'b0;
          end
        end
        pic_pkg::CMD_RELEASE_RESTORE: begin
          if (|st_q.act) begin
            st_d.act[top_level(st_q.act)] = 1'b0;
          end
          st_d.arm = 1'b1;
          st_d.arm_full = 1'b1;
        end
        pic_pkg::CMD_RESTORE_STATUS: begin
          st_d.arm = 1'b1;
          st_d.arm_full = 1'b0;
        end
        pic_pkg::CMD_READ_LEVELS: begin
          st_d.result = 18'h00000;
          st_d.result[17] = st_q.en;
          for (int i = 0; i < 8; i++) begin
            st_d.result[15-i] = st_q.req[i];
            st_d.result[7-i] = st_q.act[i];
          end
        end
        pic_pkg::CMD_DISABLE_BRK: st_d.inhibit = 1'b1;
        pic_pkg::CMD_ENABLE_BRK: st_d.inhibit = 1'b0;
        pic_pkg::CMD_CLK_ON: begin
          st_d.clk_en = 1'b1;
          st_d.clk_flag = 1'b0;
        end
        pic_pkg::CMD_CLK_OFF: st_d.clk_en = 1'b0;
        pic_pkg::CMD_CLK_SKIP: st_d.skip = st_q.clk_flag;
        pic_pkg::CMD_PWR_SKIP: st_d.skip = st_q.pwr_flag;
        default: st_d.skip = 1'b0;
      endcase
    end

    // monitor mode free instructions; a new entry reloads the window
    if (monitor_mode && scale_to_leading_one_instr_entry) begin
      st_d.free = pic_pkg::FREE_SCALE_TO_LEADING_ONE_INSTR;
    end else if (monitor_mode && (call_entry || st_q.grant)) begin
      st_d.free = pic_pkg::FREE_CALL;
    end else if (instr_retire && st_q.free != 2'h0) begin
      st_d.free = st_q.free - 2'h1;
    end

    // clock ticks: no phase relation to clock-on is assumed
    if (tick_rise && st_q.clk_en && console_clk_allow) begin
      st_d.inc_req = 1'b1;
    end else if (mem_inc_ack) begin
      st_d.inc_req = 1'b0;
    end
    // overflow set placed last so it wins over a same-cycle clock-on
    if (mem_inc_ack && st_q.inc_req && mem_inc_ovf) begin
      st_d.clk_flag = 1'b1;
    end

    // power fail flag; power_clear clears it whatever power_low is, set wins
    if (power_clear) begin
      st_d.pwr_flag = 1'b0;
      st_d.restart = auto_restart;
    end
    if (power_low && !st_q.pwr_prev) begin
      st_d.pwr_flag = 1'b1;
    end

    // arbitration and grant
    if (may_grant) begin
      st_d.grant = 1'b1;
      st_d.glevel = plevel;
      st_d.act[plevel] = 1'b1;
      st_d.req[plevel] = 1'b0;
      st_d.vector = (plevel == 3'h0 && st_q.pwr_flag) ?
                    pic_pkg::PWR_VECTOR : pic_pkg::VEC_BASE + 8'(plevel);
    end

    // without the priority system flags go to the program interrupt
    st_d.pi_req = !st_q.en && !st_q.inhibit && st_q.free == 2'h0 &&
                  (st_q.clk_flag || st_q.pwr_flag);

    // read mux; unmapped addresses answer with pslverr
    st_d.prdata = 32'h00000000;
    if (access && !st_q.pready) begin
      if (paddr == pic_pkg::OFF_CMD) begin
        st_d.prdata = 32'h00000000;
      end else if (paddr == pic_pkg::OFF_RESULT) begin
        st_d.prdata = {13'h0000, st_q.skip, st_q.result};
      end else if (paddr == pic_pkg::OFF_STATUS) begin
        st_d.prdata[pic_pkg::ST_EN] = st_q.en;
        st_d.prdata[pic_pkg::ST_INH] = st_q.inhibit;
        st_d.prdata[pic_pkg::ST_REQ +: 8] = st_q.req;
        st_d.prdata[pic_pkg::ST_ACT +: 8] = st_q.act;
        st_d.prdata[pic_pkg::ST_CLKEN] = st_q.clk_en;
        st_d.prdata[pic_pkg::ST_CLKFLAG] = st_q.clk_flag;
        st_d.prdata[pic_pkg::ST_PWR] = st_q.pwr_flag;
        st_d.prdata[pic_pkg::ST_ARM] = st_q.arm;
        st_d.prdata[pic_pkg::ST_FREE +: 2] = st_q.free;
      end else if (paddr == pic_pkg::OFF_CONFIG) begin
        st_d.prdata[1:0] = st_q.clk_src;
      end else if (paddr == pic_pkg::OFF_GRANT) begin
        st_d.prdata = {21'h000000, st_q.glevel, st_q.vector};
      end else begin
        st_d.pslverr = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flip-flops; the two addresses are constants
  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign mem_inc_req = st_q.inc_req;
  assign mem_inc_addr = pic_pkg::CLK_COUNT_ADDR;
  assign grant = st_q.grant;
  assign grant_level = st_q.glevel;
  assign grant_vector = st_q.vector;
  assign pi_req = st_q.pi_req;
  assign restore_pulse = st_q.rst_pulse;
  assign restore_full = st_q.rst_full;
  assign restart = st_q.restart;
  assign restart_addr = pic_pkg::RESTART_ADDR;

  property p_raise_en;
    @(posedge clk) disable iff (srst)
    cmd_fire && cmd == pic_pkg::CMD_RAISE |=> st_q.en == $past(ac[17]);
  endproperty
  a_raise_en: assert property (p_raise_en)
    else $error("raise did not load enable");

  property p_raise_act;
    @(posedge clk) disable iff (srst)
    cmd_fire && cmd == pic_pkg::CMD_RAISE |=>
      (st_q.act & {<<{$past(ac[7:0])}}) == {<<{$past(ac[7:0])}};
  endproperty
  a_raise_act: assert property (p_raise_act)
    else $error("raise did not set active bits");

  property p_release;
    @(posedge clk) disable iff (srst)
    cmd_fire && cmd == pic_pkg::CMD_RELEASE && |st_q.act && !st_q.arm |=>
      $countones(st_q.act) == $countones($past(st_q.act)) - 1 &&
      !st_q.arm;
  endproperty
  a_release: assert property (p_release)
    else $error("release cleared wrong count or armed restore");

  property p_restore;
    @(posedge clk) disable iff (srst)
    st_q.arm && indirect_exec |=> restore_pulse ##1 !restore_pulse;
  endproperty
  a_restore: assert property (p_restore)
    else $error("restoration not applied at indirect instruction");

  property p_clk_on;
    @(posedge clk) disable iff (srst)
    cmd_fire && cmd == pic_pkg::CMD_CLK_ON && !mem_inc_ack |=>
      st_q.clk_en && !st_q.clk_flag;
  endproperty
  a_clk_on: assert property (p_clk_on)
    else $error("clock on failed to enable or clear flag");

  property p_clk_off;
    @(posedge clk) disable iff (srst)
    cmd_fire && cmd == pic_pkg::CMD_CLK_OFF ##1 !mem_inc_req |=>
      !mem_inc_req;
  endproperty
  a_clk_off: assert property (p_clk_off)
    else $error("increment requested after clock off");

  property p_inc_prio;
    @(posedge clk) disable iff (srst)
    mem_inc_req |=> !grant;
  endproperty
  a_inc_prio: assert property (p_inc_prio)
    else $error("grant issued during clock increment");

  property p_grant_above;
    @(posedge clk) disable iff (srst)
    may_grant |=> grant && st_q.act[grant_level] &&
      above_all($past(st_q.act), grant_level);
  endproperty
  a_grant_above: assert property (p_grant_above)
    else $error("grant not above active levels");

  property p_pwr_vec;
    @(posedge clk) disable iff (srst)
    may_grant && st_q.pwr_flag |=> grant_level == 3'h0 &&
      grant_vector == pic_pkg::PWR_VECTOR;
  endproperty
  a_pwr_vec: assert property (p_pwr_vec)
    else $error("power low not on top level vector");

  property p_ovf_flag;
    @(posedge clk) disable iff (srst)
    mem_inc_req && mem_inc_ack && mem_inc_ovf |=> st_q.clk_flag;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag)
    else $error("overflow did not set clock flag");
endmodule

//--- pic_pkg.sv
// constants, command codes and register map of the priority interrupt block
package pic_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_RESULT = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CONFIG = 8'h0c;
  localparam logic [7:0] OFF_GRANT = 8'h10;
  // command word layout
  localparam int CMD_LSB = 20;
  localparam int CMD_W = 4;
  localparam int AC_W = 18;
  // status word bit positions
  localparam int ST_EN = 0;
  localparam int ST_INH = 1;
  localparam int ST_REQ = 2;
  localparam int ST_ACT = 10;
  localparam int ST_CLKEN = 18;
  localparam int ST_CLKFLAG = 19;
  localparam int ST_PWR = 20;
  localparam int ST_ARM = 21;
  localparam int ST_FREE = 22;
  // clock source select values
  localparam logic [1:0] SRC_LINE = 2'h0;
  localparam logic [1:0] SRC_OSC = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;
  // fixed addresses
  localparam logic [17:0] CLK_COUNT_ADDR = 18'h00007;
  localparam logic [17:0] RESTART_ADDR = 18'h00000;
  localparam logic [7:0] PWR_VECTOR = 8'h34;
  localparam logic [7:0] VEC_BASE = 8'h40;
  // free instruction counts in monitor mode
  localparam logic [1:0] FREE_CALL = 2'h1;
  localparam logic [1:0] FREE_SCALE_TO_LEADING_ONE_INSTR = 2'h2;
  // longest delay to first clock increment, and its cycle count at 100 MHz
  localparam int CLK_HZ = 100000000;
  localparam int FIRST_TICK_MS = 17;
  localparam int FIRST_TICK_CYC = FIRST_TICK_MS * (CLK_HZ / 1000);
  typedef enum logic [3:0] {
    CMD_NOP, CMD_SKIP_INACTIVE, CMD_RAISE, CMD_RELEASE,
    CMD_RELEASE_RESTORE, CMD_RESTORE_STATUS, CMD_READ_LEVELS,
    CMD_DISABLE_BRK, CMD_ENABLE_BRK, CMD_CLK_ON, CMD_CLK_OFF,
    CMD_CLK_SKIP, CMD_PWR_SKIP
  } pic_cmd_e;
endpackage

//--- pic_mem_model.sv
// memory increment responder standing for the i/o processor
`timescale 1ns/1ps
module pic_mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // increment cycle
  input wire logic mem_inc_req,
  input wire logic [17:0] mem_inc_addr,
  output logic mem_inc_ack,
  output logic mem_inc_ovf,
  // bench control
  input wire logic slow,
  input wire logic load_en,
  input wire logic [17:0] load_val,
  output logic [17:0] count
);
  logic [3:0] wait_q;
  logic done_q;

  // done_q keeps a held request from being served twice
  always_ff @(posedge clk) begin
    mem_inc_ack <= 1'b0;
    mem_inc_ovf <= 1'b0;
    if (srst) begin
      count <= 18'h00000;
      wait_q <= 4'h0;
      done_q <= 1'b0;
    end else if (load_en) begin
      count <= load_val;
    end else if (mem_inc_req && !done_q && mem_inc_addr == 18'h00007) begin
      if (wait_q == (slow ? 4'h6 : 4'h0)) begin
        mem_inc_ack <= 1'b1;
        mem_inc_ovf <= &count;
        count <= count + 18'h00001;
        done_q <= 1'b1;
        wait_q <= 4'h0;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end else if (!mem_inc_req) begin
      done_q <= 1'b0;
    end
  end
endmodule

//--- test_priority_interrupt_control.sv
// self-checking bench for the priority interrupt controller
`timescale 1ns/1ps
module test_priority_interrupt_control;
  logic clk = 1'b0, srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, indirect_exec = 1'b0, power_low = 1'b0;
  logic power_clear = 1'b0, auto_restart = 1'b1, slow = 1'b0;
  logic load_en = 1'b0, mem_inc_req, mem_inc_ack, mem_inc_ovf;
  logic [2:0] tk = 3'h0;
  logic [3:0] hw_req = 4'h0;
  logic console_clk_allow = 1'b1, monitor_mode = 1'b0, scale_to_leading_one_instr_entry = 1'b0;
  logic instr_retire = 1'b0, pi_req;
  logic [17:0] load_val = 18'h0, mem_inc_addr, count;
  logic restore_pulse, restore_full, restart;
  logic [31:0] rd_v;
  logic rd_e;
  int fail_count = 0, tests_run = 0, rp_cnt = 0, rs_cnt = 0;
  localparam logic [31:0] M = 32'hffff_ffff;
  localparam logic [31:0] SK = 32'h0004_0000;

  always #5 clk = ~clk;

  pic_top #(.CLK_LEVEL(3)) pic_top_i (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hw_req(hw_req),
    .indirect_exec(indirect_exec), .instr_retire(instr_retire),
    .monitor_mode(monitor_mode), .call_entry(1'b0),
    .scale_to_leading_one_instr_entry(scale_to_leading_one_instr_entry),
    .line_tick(tk[0]), .osc_tick(tk[1]), .ext_tick(tk[2]),
    .console_clk_allow(console_clk_allow), .mem_inc_req(mem_inc_req),
    .mem_inc_addr(mem_inc_addr), .mem_inc_ack(mem_inc_ack),
    .mem_inc_ovf(mem_inc_ovf), .power_low(power_low),
    .power_clear(power_clear), .auto_restart(auto_restart),
    .grant(), .grant_level(), .grant_vector(), .pi_req(pi_req),
    .restore_pulse(restore_pulse), .restore_full(restore_full),
    .restart(restart), .restart_addr()
  );

  pic_mem_model pic_mem_model_i (
    .clk(clk), .srst(srst), .mem_inc_req(mem_inc_req),
    .mem_inc_addr(mem_inc_addr), .mem_inc_ack(mem_inc_ack),
    .mem_inc_ovf(mem_inc_ovf), .slow(slow), .load_en(load_en),
    .load_val(load_val), .count(count)
  );

  // one-cycle outputs are counted here so no pulse is missed
  always @(posedge clk) begin
    if (restore_pulse === 1'b1) rp_cnt <= rp_cnt + 1;
    if (restart === 1'b1) rs_cnt <= rs_cnt + 1;
  end

  task automatic end_sim;
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // apb transfer: request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd_v & m);
  endtask

  // whole status word read and compared
  task automatic schk(input string nm, input logic [31:0] e);
    rchk(nm, pic_pkg::OFF_STATUS, M, e);
  endtask

  // command word: ac bit n of the processor sits at pwdata bit 17-n
  task automatic cmd(input pic_pkg::pic_cmd_e c, input logic [17:0] ac);
    apb(1'b1, pic_pkg::OFF_CMD, {8'h00, 4'(c), 2'b00, ac});
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [17:0] acb(input int n);
    return 18'h00001 << (17 - n);
  endfunction

  function automatic logic [31:0] sx(input logic [7:0] rq,
                                    input logic [7:0] ac,
                                    input logic [31:0] o);
    return o | {14'h0, ac, rq, 2'b00};
  endfunction

  task automatic pulse_ind;
    @(posedge clk) indirect_exec <= 1'b1;
    @(posedge clk) indirect_exec <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // one tick on the chosen source, then time for the increment cycle
  task automatic tick(input int s);
    apb(1'b1, pic_pkg::OFF_CONFIG, 32'(s));
    @(posedge clk) tk[s] <= 1'b1;
    repeat (2) @(posedge clk);
    tk[s] <= 1'b0;
    repeat (20) @(posedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rchk("status_rst", pic_pkg::OFF_STATUS, M, 32'h0);
    rchk("grant_rst", pic_pkg::OFF_GRANT, M, 32'h0);
    rchk("unmapped", 8'h14, M, 32'h0);
    chk("slverr", 32'h1, {31'h0, rd_e});
    apb(1'b1, pic_pkg::OFF_STATUS, M);
    rchk("status_ro", pic_pkg::OFF_STATUS, M, 32'h0);
    // raise: enable, requests 4 and 6, level 0 active
    cmd(pic_pkg::CMD_RAISE, acb(0) | acb(6) | acb(8) | acb(10));
    schk("raise", sx(8'h50, 8'h01, 32'h1));
    cmd(pic_pkg::CMD_READ_LEVELS, 18'h0);
    rchk("levels", pic_pkg::OFF_RESULT, M, 32'h0002_0a80);
    cmd(pic_pkg::CMD_SKIP_INACTIVE, acb(10));
    rchk("skip_act", pic_pkg::OFF_RESULT, SK, SK);
    cmd(pic_pkg::CMD_SKIP_INACTIVE, acb(11) | acb(14));
    rchk("skip_none", pic_pkg::OFF_RESULT, SK, 32'h0);
    cmd(pic_pkg::CMD_SKIP_INACTIVE, acb(0));
    rchk("skip_en", pic_pkg::OFF_RESULT, SK, SK);
    // release level 0 lets request 4 through, request 6 waits
    cmd(pic_pkg::CMD_RELEASE, 18'h0);
    schk("release", sx(8'h40, 8'h10, 32'h1));
    rchk("grant4", pic_pkg::OFF_GRANT, M, 32'h0000_0444);
    pulse_ind();
    chk("no_restore", 32'h0, 32'(rp_cnt));
    cmd(pic_pkg::CMD_RELEASE_RESTORE, 18'h0);
    schk("rel_rst", sx(8'h0, 8'h40, 32'h0020_0001));
    rchk("grant6", pic_pkg::OFF_GRANT, M, 32'h0000_0646);
    pulse_ind();
    chk("restore1", 32'h1, 32'(rp_cnt));
    chk("full1", 32'h1, {31'h0, restore_full});
    cmd(pic_pkg::CMD_RESTORE_STATUS, 18'h0);
    schk("res_st", sx(8'h0, 8'h40, 32'h0020_0001));
    pulse_ind();
    chk("restore2", 32'h2, 32'(rp_cnt));
    chk("full0", 32'h0, {31'h0, restore_full});
    // clock: one tick per source, then an overflow with a slow memory
    @(posedge clk) load_en <= 1'b1;
    load_val <= 18'h3fffc;
    @(posedge clk) load_en <= 1'b0;
    cmd(pic_pkg::CMD_CLK_ON, 18'h0);
    for (int s = 0; s < 3; s++) tick(s);
    chk("count3", 32'h0003_ffff, 32'(count));
    rchk("config", pic_pkg::OFF_CONFIG, 32'h3, 32'h2);
    slow <= 1'b1;
    tick(0);
    chk("count_ovf", 32'h0, 32'(count));
    schk("clk_flag", sx(8'h0, 8'h48, 32'h000c_0001));
    rchk("grant3", pic_pkg::OFF_GRANT, M, 32'h0000_0343);
    cmd(pic_pkg::CMD_CLK_SKIP, 18'h0);
    rchk("clk_skip", pic_pkg::OFF_RESULT, SK, SK);
    cmd(pic_pkg::CMD_CLK_OFF, 18'h0);
    tick(0);
    chk("count_off", 32'h0, 32'(count));
    cmd(pic_pkg::CMD_CLK_ON, 18'h0);
    schk("clk_on", sx(8'h0, 8'h48, 32'h0004_0001));
    // power fail takes the top level with its own vector
    @(posedge clk) power_low <= 1'b1;
    repeat (4) @(posedge clk);
    rchk("grant_pwr", pic_pkg::OFF_GRANT, M, 32'h0000_0034);
    cmd(pic_pkg::CMD_PWR_SKIP, 18'h0);
    rchk("pwr_skip", pic_pkg::OFF_RESULT, SK, SK);
    schk("pwr_st", sx(8'h0, 8'h49, 32'h0014_0001));
    @(posedge clk) power_low <= 1'b0;
    power_clear <= 1'b1;
    @(posedge clk) power_clear <= 1'b0;
    repeat (3) @(posedge clk);
    chk("restart", 32'h1, 32'(rs_cnt));
    schk("pwr_clr", sx(8'h0, 8'h49, 32'h0004_0001));
    // inhibited request waits for the enable command
    repeat (3) cmd(pic_pkg::CMD_RELEASE, 18'h0);
    cmd(pic_pkg::CMD_DISABLE_BRK, 18'h0);
    cmd(pic_pkg::CMD_RAISE, acb(0) | acb(7));
    schk("inhibit", sx(8'h20, 8'h0, 32'h0004_0003));
    cmd(pic_pkg::CMD_ENABLE_BRK, 18'h0);
    schk("enable", sx(8'h0, 8'h20, 32'h0004_0001));
    rchk("grant5", pic_pkg::OFF_GRANT, M, 32'h0000_0545);
    // an external line request is granted but never stored
    hw_req <= 4'h2;
    repeat (4) @(posedge clk);
    hw_req <= 4'h0;
    rchk("grant1", pic_pkg::OFF_GRANT, M, 32'h0000_0141);
    schk("hw_req", sx(8'h0, 8'h22, 32'h0004_0001));
    // monitor free window: loaded by normalize, counted down by retire
    @(posedge clk) monitor_mode <= 1'b1;
    scale_to_leading_one_instr_entry <= 1'b1;
    @(posedge clk) scale_to_leading_one_instr_entry <= 1'b0;
    schk("free2", sx(8'h0, 8'h22, 32'h0084_0001));
    @(posedge clk) instr_retire <= 1'b1;
    @(posedge clk) instr_retire <= 1'b0;
    schk("free1", sx(8'h0, 8'h22, 32'h0044_0001));
    @(posedge clk) instr_retire <= 1'b1;
    monitor_mode <= 1'b0;
    @(posedge clk) instr_retire <= 1'b0;
    // console switch holds the count; with the system off, overflow
    // goes to the program interrupt
    @(posedge clk) load_en <= 1'b1;
    load_val <= 18'h3ffff;
    @(posedge clk) load_en <= 1'b0;
    console_clk_allow <= 1'b0;
    tick(0);
    chk("console_off", 32'h0003_ffff, 32'(count));
    console_clk_allow <= 1'b1;
    cmd(pic_pkg::CMD_RAISE, 18'h0);
    tick(0);
    chk("count_wrap", 32'h0, 32'(count));
    chk("pi_req", 32'h1, {31'h0, pi_req});
    cmd(pic_pkg::CMD_CLK_ON, 18'h0);
    chk("pi_clr", 32'h0, {31'h0, pi_req});
    end_sim();
  end
endmodule
